// *** src/icd_pkg.sv ***
`default_nettype none
package icd_pkg;
  // register bus geometry
  localparam int ICD_AW = 8;
  localparam int ICD_DW = 32;
  localparam logic [ICD_AW-1:0] ICD_OFS_CTRL = 8'H00;
  localparam logic [ICD_AW-1:0] ICD_OFS_STATUS = 8'H04;
  localparam logic [ICD_AW-1:0] ICD_OFS_TXDATA = 8'H08;
  // control register fields
  localparam int ICD_CTRL_ADDR_LSB = 0;
  localparam int ICD_CTRL_ADDR_W = 5;
  localparam int ICD_CTRL_SRQ_BIT = 8;
  // status register fields
  localparam int ICD_ST_LISTEN = 0;
  localparam int ICD_ST_TALK = 1;
  localparam int ICD_ST_REMOTE = 2;
  localparam int ICD_ST_LOCKOUT = 3;
  localparam int ICD_ST_SPOLL = 4;
  localparam int ICD_ST_SRQ = 5;
  localparam int ICD_ST_TXFULL = 6;
  localparam int ICD_ST_REN = 7;
  localparam int ICD_ST_ATN = 8;
  // transmit register fields
  localparam int ICD_TX_LAST_BIT = 8;
  // primary address limits and reset value
  localparam logic [4:0] ICD_ADDR_MAX = 5'H1E;
  localparam logic [4:0] ICD_ADDR_RST = 5'H0A;
  // command codes, seven bits
  localparam logic [6:0] ICD_GTL = 7'H01;
  localparam logic [6:0] ICD_SDC = 7'H04;
  localparam logic [6:0] ICD_GET = 7'H08;
  localparam logic [6:0] ICD_LLO = 7'H11;
  localparam logic [6:0] ICD_DCL = 7'H14;
  localparam logic [6:0] ICD_SPE = 7'H18;
  localparam logic [6:0] ICD_SPD = 7'H19;
  localparam logic [6:0] ICD_UNL = 7'H3F;
  localparam logic [6:0] ICD_UNT = 7'H5F;
  // group select in code bits 6:5
  localparam logic [1:0] ICD_GRP_LAG = 2'H1;
  localparam logic [1:0] ICD_GRP_TAG = 2'H2;
  localparam logic [1:0] ICD_GRP_SCG = 2'H3;
  // synchroniser bit positions of the pin vector
  localparam int ICD_PIN_W = 13;
  localparam int ICD_PIN_ATN = 8;
  localparam int ICD_PIN_IFC = 9;
  localparam int ICD_PIN_REN = 10;
  localparam int ICD_PIN_EOI = 11;
  localparam int ICD_PIN_DAV = 12;
endpackage : icd_pkg
`default_nettype wire

// *** src/icd_cmd_if.sv ***
`timescale 1ns/1ps
`default_nettype none
interface icd_cmd_if;
  logic [6:0] code;
  logic [4:0] my_addr;
  logic is_gtl;
  logic is_sdc;
  logic is_get;
  logic is_llo;
  logic is_dcl;
  logic is_spe;
  logic is_spd;
  logic is_unl;
  logic is_unt;
  logic is_my_lag;
  logic is_my_tag;
  logic is_scg;
  modport classifier(
    input code, my_addr,
    output is_gtl, is_sdc, is_get, is_llo, is_dcl, is_spe, is_spd,
    output is_unl, is_unt, is_my_lag, is_my_tag, is_scg
  );
  modport user(
    output code, my_addr,
    input is_gtl, is_sdc, is_get, is_llo, is_dcl, is_spe, is_spd,
    input is_unl, is_unt, is_my_lag, is_my_tag, is_scg
  );
endinterface : icd_cmd_if
`default_nettype wire

// *** src/icd_classify.sv ***
`timescale 1ns/1ps
`default_nettype none
module icd_classify (
  icd_cmd_if.classifier c
);
  import icd_pkg::*;

  wire [1:0] grp = c.code[6:5];
  wire addr_hit = (c.code[4:0] == c.my_addr);

  assign c.is_gtl = (c.code == ICD_GTL);
  assign c.is_sdc = (c.code == ICD_SDC);
  assign c.is_get = (c.code == ICD_GET);
  assign c.is_llo = (c.code == ICD_LLO);
  assign c.is_dcl = (c.code == ICD_DCL);
  assign c.is_spe = (c.code == ICD_SPE);
  assign c.is_spd = (c.code == ICD_SPD);
  assign c.is_unl = (c.code == ICD_UNL);
  assign c.is_unt = (c.code == ICD_UNT);
  // all-ones address field is unlisten/untalk, never an address
  assign c.is_my_lag = (grp == ICD_GRP_LAG) && addr_hit && !c.is_unl; // R15
  assign c.is_my_tag = (grp == ICD_GRP_TAG) && addr_hit && !c.is_unt; // R16
  // secondary group is flagged so the caller can ignore it
  assign c.is_scg = (grp == ICD_GRP_SCG); // R18
endmodule : icd_classify
`default_nettype wire

// *** src/icd_top.sv ***
// Operation
// (R1) attention, interface clear, remote enable come only from controller; inputs only.
// (R2) service request line held asserted while service is needed, until serviced.
// (R3) end-or-identify accompanies only the final byte of a multi-byte message.
// (R4) interface clear drops the device into talker idle and listener idle.
// (R5) bytes taken with attention true are addresses or bus commands.
// (R6) universal commands act whether or not the device is addressed.
// (R7) local lockout code 11 sets lockout, disabling front panel controls.
// (R8) device clear code 14 restores power-up defaults.
// (R9) code 18 enters serial poll mode, code 19 leaves it.
// (R10) selective device clear 04 restores defaults only when addressed to listen.
// (R11) go-to-local 01 while listener leaves remote mode.
// (R12) group execute trigger 08 while listener fires the trigger.
// (R13) unlisten 3F with attention forces listener idle.
// (R14) untalk 5F with attention forces talker idle.
// (R15) listen address 20-3F matching primary address makes device listener.
// (R16) talk address 40-5F matching primary address makes device talker.
// (R17) commands are seven bits; eighth data line is ignored.
// (R18) secondary addressing absent; secondary group bytes do nothing.
// (R19) attention-false bytes forwarded as characters only while listener.
// (R20) addressed commands and data need listen addressing; universal need attention.
// (R21) controller sends unlisten, listen address, command, then releases attention.
// (R22) with remote enable asserted, device enters remote when addressed; here only its listen address sets remote, its talk address does not.
// (R23) primary address is a stored value from 0 to 30.
// (R24) bus lines are active low and inverted before interpretation.
// (R25) talker waits for ready-for-data, then asserts data valid; here data valid is an input only, and an external handshake signals tx_accept.
// (R26) reset leaves both idle states, local mode, no lockout, no serial poll.
//
// Design decisions made here: the register offsets and strobed register access.
`timescale 1ns/1ps
`default_nettype none
module icd_top (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic [icd_pkg::ICD_AW-1:0] reg_addr,
  input wire logic [icd_pkg::ICD_DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [icd_pkg::ICD_DW-1:0] reg_rdata,
  input wire logic [7:0] dio_n_in,
  output logic [7:0] dio_n_out,
  output logic dio_oe,
  input wire logic atn_n,
  input wire logic ifc_n,
  input wire logic ren_n,
  input wire logic dav_n,
  input wire logic eoi_n_in,
  output logic eoi_n_out,
  output logic eoi_oe,
  output logic srq_n_out,
  output logic srq_oe,
  input wire logic tx_accept,
  output logic rx_valid,
  output logic [6:0] rx_char,
  output logic rx_last,
  output logic remote,
  output logic lockout,
  output logic trigger,
  output logic dev_clear
);
  import icd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers: data is sampled through the same two stages as the
  // strobe, so a byte and its valid edge stay aligned
  logic [ICD_PIN_W-1:0] pin_meta;
  logic [ICD_PIN_W-1:0] pin_sync;
  logic dav_prev;
  // attention, clear and remote enable are only ever sampled here
  wire [ICD_PIN_W-1:0] pin_raw = {dav_n, eoi_n_in, ren_n, ifc_n, atn_n, dio_n_in}; // R1

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      pin_meta <= '1;
      pin_sync <= '1;
      dav_prev <= 1'H0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      dav_prev <= !pin_sync[ICD_PIN_DAV];
    end
  end

  // low level is true on every line
  wire [7:0] dio_true = ~pin_sync[7:0]; // R24
  wire atn_s = !pin_sync[ICD_PIN_ATN]; // R24
  wire ifc_s = !pin_sync[ICD_PIN_IFC];
  wire ren_s = !pin_sync[ICD_PIN_REN];
  wire eoi_s = !pin_sync[ICD_PIN_EOI];
  wire dav_s = !pin_sync[ICD_PIN_DAV];
  wire byte_stb = dav_s && !dav_prev;
  wire cmd_stb = byte_stb && atn_s; // R5
  wire data_stb = byte_stb && !atn_s;

  ////////////////////////////////////////////////////////////////////////////
  // command classification
  logic [4:0] prim_addr;
  icd_cmd_if c ();
  assign c.code = dio_true[6:0]; // R17
  assign c.my_addr = prim_addr;

  icd_classify u_classify (
    .c(c)
  );

  ////////////////////////////////////////////////////////////////////////////
  // interface state
  logic listener;
  logic talker;
  logic spoll;
  logic srq_req;
  logic tx_full;
  logic [7:0] tx_byte;
  logic tx_last;

  // secondary bytes never reach any of the decodes below
  wire cmd_ok = cmd_stb && !c.is_scg; // R18
  wire do_unl = cmd_ok && c.is_unl; // R13
  wire do_unt = cmd_ok && c.is_unt; // R14
  wire do_lag = cmd_ok && c.is_my_lag; // R15
  wire do_tag = cmd_ok && c.is_my_tag; // R16
  wire do_llo = cmd_ok && c.is_llo; // R6
  wire do_dcl = cmd_ok && c.is_dcl; // R6
  wire do_spe = cmd_ok && c.is_spe;
  wire do_spd = cmd_ok && c.is_spd;
  wire do_sdc = cmd_ok && c.is_sdc && listener; // R20
  wire do_gtl = cmd_ok && c.is_gtl && listener; // R11
  wire do_get = cmd_ok && c.is_get && listener; // R12
  wire do_clear = do_dcl || do_sdc; // R8 R10
  // the controller addressing the device as talker in serial poll is the service
  wire serviced = spoll && do_tag;

  wire next_listener = ifc_s ? 1'H0 : do_unl ? 1'H0 : do_lag ? 1'H1 : listener; // R4
  wire next_talker = ifc_s ? 1'H0 : do_unt ? 1'H0 : do_tag ? 1'H1 : talker; // R4
  wire next_spoll = ifc_s ? 1'H0 : do_spe ? 1'H1 : do_spd ? 1'H0 : spoll; // R9
  // leaving remote enable returns local and drops lockout together
  wire next_remote = !ren_s ? 1'H0 : do_lag ? 1'H1 : do_gtl ? 1'H0 : remote; // R22
  wire next_lockout = !ren_s ? 1'H0 : do_llo ? 1'H1 : lockout; // R7

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      listener <= 1'H0; // R26
      talker <= 1'H0;
      spoll <= 1'H0;
      remote <= 1'H0;
      lockout <= 1'H0;
    end else begin
      listener <= next_listener;
      talker <= next_talker;
      spoll <= next_spoll;
      remote <= next_remote;
      lockout <= next_lockout;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      trigger <= 1'H0;
      dev_clear <= 1'H0;
      rx_valid <= 1'H0;
      rx_char <= 7'H00;
      rx_last <= 1'H0;
    end else begin
      trigger <= do_get && !ifc_s;
      dev_clear <= do_clear;
      rx_valid <= data_stb && listener && !ifc_s; // R19 R20
      if (data_stb) begin
        rx_char <= dio_true[6:0];
        rx_last <= eoi_s; // R3
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register port
  wire sel_ctrl = (reg_addr == ICD_OFS_CTRL);
  wire sel_status = (reg_addr == ICD_OFS_STATUS);
  wire sel_tx = (reg_addr == ICD_OFS_TXDATA);
  wire wr_ctrl = reg_wr && sel_ctrl;
  wire wr_tx = reg_wr && sel_tx;
  wire [4:0] wr_addr = reg_wdata[ICD_CTRL_ADDR_LSB +: ICD_CTRL_ADDR_W];
  // an out-of-range address is dropped so the old one keeps working
  wire addr_ok = (wr_addr <= ICD_ADDR_MAX); // R23
  // a software request written in the same cycle as a service wins
  wire next_srq = wr_ctrl ? reg_wdata[ICD_CTRL_SRQ_BIT] :
                  (serviced || do_clear) ? 1'H0 : srq_req; // R2
  wire next_tx_full = wr_tx ? 1'H1 : (tx_accept || do_clear) ? 1'H0 : tx_full;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      prim_addr <= ICD_ADDR_RST;
      srq_req <= 1'H0;
      tx_full <= 1'H0;
      tx_byte <= 8'H00;
      tx_last <= 1'H0;
    end else begin
      if (wr_ctrl && addr_ok) begin
        prim_addr <= wr_addr;
      end
      srq_req <= next_srq;
      tx_full <= next_tx_full;
      if (wr_tx) begin
        tx_byte <= reg_wdata[7:0];
        tx_last <= reg_wdata[ICD_TX_LAST_BIT];
      end
    end
  end

  wire [ICD_DW-1:0] ctrl_view = ICD_DW'({srq_req, 3'H0, prim_addr});
  wire [ICD_DW-1:0] status_view = ICD_DW'({atn_s, ren_s, tx_full, srq_req, spoll,
                                           lockout, remote, talker, listener});
  wire [ICD_DW-1:0] tx_view = ICD_DW'({tx_last, tx_byte});
  wire [ICD_DW-1:0] rd_mux = sel_ctrl ? ctrl_view : sel_status ? status_view :
                             sel_tx ? tx_view : '0;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      reg_rdata <= '0;
    end else begin
      reg_rdata <= reg_rd ? rd_mux : '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus drivers; the external acceptor handshake signals tx_accept
  // never drive data while attention is true, or another talker would clash
  wire drive_data = talker && !atn_s && tx_full && !ifc_s;

  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      dio_n_out <= 8'HFF;
      dio_oe <= 1'H0;
      eoi_n_out <= 1'H1;
      eoi_oe <= 1'H0;
      srq_n_out <= 1'H1;
      srq_oe <= 1'H0;
    end else begin
      dio_n_out <= ~tx_byte; // R24
      dio_oe <= drive_data;
      eoi_n_out <= !(drive_data && tx_last); // R3
      eoi_oe <= drive_data && tx_last; // R3
      srq_n_out <= !srq_req; // R2
      srq_oe <= srq_req; // R2
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);

  a_ifc_idle: assert property (ifc_s |=> !listener && !talker) // R4
    else $error("interface clear did not idle the device");
  a_unl_idle: assert property (do_unl |=> !listener) // R13
    else $error("unlisten left listener active");
  a_unt_idle: assert property (do_unt && !ifc_s |=> !talker) // R14
    else $error("untalk left talker active");
  a_lag_listen: assert property (cmd_stb && !c.is_unl && c.code[6:5] == 2'H1 // R15
    && c.code[4:0] == prim_addr && !ifc_s |=> listener)
    else $error("own listen address not taken");
  a_tag_talk: assert property (cmd_stb && !c.is_unt && c.code[6:5] == 2'H2 // R16
    && c.code[4:0] == prim_addr && !ifc_s |=> talker)
    else $error("own talk address not taken");
  a_llo_lock: assert property (cmd_stb && c.code == 7'H11 && ren_s |=> lockout) // R7
    else $error("lockout not set");
  a_clear_cause: assert property (dev_clear |-> $past(cmd_stb) && // R8 R10
    ($past(c.code) == 7'H14 || ($past(c.code) == 7'H04 && $past(listener))))
    else $error("device clear without cause");
  a_spoll_mode: assert property (cmd_stb && c.code == 7'H18 && !ifc_s |=> spoll // R9
    ##0 (!(cmd_stb && c.code == 7'H19) || ifc_s) [*1] ##0 1'H1)
    else $error("serial poll enable missed");
  a_spd_exit: assert property (cmd_stb && c.code == 7'H19 |=> !spoll) // R9
    else $error("serial poll disable missed");
  a_rx_gate: assert property (rx_valid |-> $past(listener) && !$past(atn_s)) // R19 R20
    else $error("data forwarded while not listener");
  a_rx_fwd: assert property (data_stb && listener && !ifc_s |=> rx_valid && // R19
    rx_char == $past(dio_true[6:0]))
    else $error("listener data not forwarded");
  a_gtl_local: assert property (cmd_stb && c.code == 7'H01 && listener && ren_s // R11
    && !c.is_my_lag |=> !remote)
    else $error("go to local ignored");
  a_get_trig: assert property (trigger |-> $past(listener) && $past(c.code) == 7'H08) // R12
    else $error("trigger without addressed command");
  a_srq_hold: assert property (srq_req ##1 srq_req |-> srq_oe && !srq_n_out) // R2
    else $error("service request not driven");
  a_eoi_last: assert property (eoi_oe |-> dio_oe && !eoi_n_out && $past(tx_last)) // R3
    else $error("end marker without final byte");
  a_no_drive_atn: assert property (atn_s ##1 atn_s |-> !dio_oe) // R5
    else $error("data driven during attention");
  a_reset_idle: assert property ($rose(rstn) |-> !listener && !talker && !remote // R26
    && !lockout && !spoll)
    else $error("state not idle after reset");
  a_reset_outs: assert property ($rose(rstn) |-> !dio_oe && !eoi_oe && !srq_oe // R26
    && !rx_valid && !trigger && !dev_clear && reg_rdata == '0)
    else $error("outputs not quiet after reset");

  // interface clear, addressing, remote, gating of the addressed commands, data lines and service request
  a_ifc_spoll: assert property (ifc_s |=> !spoll) // R4
    else $error("interface clear left serial poll on");
  a_ifc_no_rx: assert property (ifc_s |=> !rx_valid && !trigger) // R4
    else $error("data or trigger passed during interface clear");
  a_lag_other: assert property (cmd_stb && c.code[6:5] == 2'H1 // R15
    && c.code[4:0] != prim_addr && !listener |=> !listener)
    else $error("foreign listen address taken");
  a_tag_other: assert property (cmd_stb && c.code[6:5] == 2'H2 // R16
    && c.code[4:0] != prim_addr && !talker |=> !talker)
    else $error("foreign talk address taken");
  a_lag_remote: assert property (cmd_stb && c.code[6:5] == 2'H1 && ren_s // R22
    && c.code[4:0] == prim_addr && c.code != ICD_UNL |=> remote)
    else $error("own listen address did not enter remote");
  // remote enable is the only thing that drops remote and lockout together
  a_ren_local: assert property (!ren_s |=> !remote && !lockout) // R22
    else $error("remote kept without remote enable");
  a_gtl_keeps_lock: assert property (cmd_stb && c.code == ICD_GTL && lockout && ren_s // R11
    |=> lockout)
    else $error("go to local dropped lockout");
  a_dcl_any: assert property (cmd_stb && c.code == ICD_DCL |=> dev_clear) // R6
    else $error("device clear ignored");
  a_sdc_gate: assert property (cmd_stb && c.code == ICD_SDC && !listener |=> !dev_clear) // R10
    else $error("selective clear acted while not listener");
  a_get_gate: assert property (cmd_stb && c.code == ICD_GET && !listener |=> !trigger) // R20
    else $error("trigger fired while not listener");
  // a secondary byte right after our address must not move any state
  a_scg_inert: assert property (cmd_stb && c.code[6:5] == 2'H3 && !ifc_s && ren_s // R18
    |=> $stable({listener, talker, spoll, remote, lockout}) && !dev_clear && !trigger)
    else $error("secondary byte changed state");
  a_rx_eoi: assert property (data_stb && listener && !ifc_s |=> rx_last == $past(eoi_s)) // R3
    else $error("end marker not captured with byte");
  a_talk_drive: assert property (talker && !atn_s && tx_full && !ifc_s |=> dio_oe) // R16
    else $error("talker did not drive its byte");
  a_dio_value: assert property (dio_oe |-> dio_n_out == ~$past(tx_byte)) // R24
    else $error("data lines not inverted byte");
  a_srq_keep: assert property (srq_req && !cmd_stb && !reg_wr |=> srq_req) // R2
    else $error("service request dropped unserviced");
  a_srq_service: assert property (cmd_stb && spoll && c.code[6:5] == 2'H2 && !reg_wr // R2
    && c.code[4:0] == prim_addr && c.code != ICD_UNT |=> !srq_req)
    else $error("service request kept after poll");
  a_addr_keep: assert property (reg_wr && reg_addr == ICD_OFS_CTRL // R23
    && reg_wdata[4:0] > ICD_ADDR_MAX |=> $stable(prim_addr))
    else $error("out of range address stored");

  c_listen_data: cover property (do_lag ##[1:50] rx_valid);
  c_poll: cover property (do_spe ##[1:50] serviced);
  c_trigger: cover property (trigger);
  c_talk_last: cover property (eoi_oe);
  c_dev_clear: cover property (dev_clear);
endmodule : icd_top
`default_nettype wire

// *** testbench/icd_ctrl_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module icd_ctrl_model (
  input wire logic sys_clk,
  output logic [7:0] dio_n,
  output logic eoi_n,
  output logic atn_n,
  output logic ifc_n,
  output logic ren_n,
  output logic dav_n
);
  // all lines idle high: released lines float up through the bus pull-ups
  initial begin
    dio_n = 8'HFF;
    eoi_n = 1'H1;
    atn_n = 1'H1;
    ifc_n = 1'H1;
    ren_n = 1'H1;
    dav_n = 1'H1;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one byte; attention is left as set so a command run keeps it asserted
  task automatic send(input logic [7:0] b, input logic atn, input logic eoi);
    @(posedge sys_clk);
    atn_n <= ~atn;
    dio_n <= ~b;
    eoi_n <= ~eoi;
    repeat (3) @(posedge sys_clk);
    dav_n <= 1'H0;
    repeat (3) @(posedge sys_clk);
    dav_n <= 1'H1;
    dio_n <= 8'HFF;
    eoi_n <= 1'H1;
    repeat (4) @(posedge sys_clk);
  endtask : send
  task automatic lines(input logic atn, input logic ren, input logic ifc);
    @(posedge sys_clk);
    atn_n <= ~atn;
    ren_n <= ~ren;
    ifc_n <= ~ifc;
    repeat (4) @(posedge sys_clk);
  endtask : lines
endmodule : icd_ctrl_model
`default_nettype wire

// *** testbench/icd_top_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module icd_top_tb;
  import icd_pkg::*;
  logic sys_clk, rstn, reg_wr, reg_rd, tx_accept, rd_d;
  logic [ICD_AW-1:0] reg_addr;
  logic [ICD_DW-1:0] reg_wdata, reg_rdata;
  logic [7:0] dio_n_out, m_dio, dio_bus;
  logic dio_oe, eoi_n_out, eoi_oe, srq_n_out, srq_oe, m_eoi, eoi_bus;
  logic atn_n, ifc_n, ren_n, dav_n, rx_valid, rx_last, remote, lockout, trigger, dev_clear;
  logic [6:0] rx_char;
  logic l, t, rm, lk, sp, sq, tf, rn, an;
  logic [4:0] pa;
  logic [31:0] rd_q[$];
  logic [7:0] rx_q[$];
  int n_fail, checks, n_trig, n_clr, cyc;
  int seed = 78;
  // wired-and of both parties on the shared low-true lines
  assign dio_bus = m_dio & (dio_oe ? dio_n_out : 8'HFF);
  assign eoi_bus = m_eoi & (eoi_oe ? eoi_n_out : 1'H1);
  icd_ctrl_model i_ctl (.sys_clk(sys_clk), .dio_n(m_dio), .eoi_n(m_eoi), .atn_n(atn_n),
    .ifc_n(ifc_n), .ren_n(ren_n), .dav_n(dav_n));
  icd_top i_dut (.sys_clk(sys_clk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .dio_n_in(dio_bus),
    .dio_n_out(dio_n_out), .dio_oe(dio_oe), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n),
    .dav_n(dav_n), .eoi_n_in(eoi_bus), .eoi_n_out(eoi_n_out), .eoi_oe(eoi_oe),
    .srq_n_out(srq_n_out), .srq_oe(srq_oe), .tx_accept(tx_accept), .rx_valid(rx_valid),
    .rx_char(rx_char), .rx_last(rx_last), .remote(remote), .lockout(lockout),
    .trigger(trigger), .dev_clear(dev_clear));
  initial begin
    sys_clk = 1'H0;
    forever #50 sys_clk = ~sys_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic print_verdict();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp
  task automatic cmp_rd(input logic [31:0] exp, input logic [31:0] got);
    cmp("rdata", exp, got);
  endtask : cmp_rd
  task automatic cmp_rx(input logic [8:0] exp, input logic [8:0] got);
    cmp("rx", 32'(exp), 32'(got));
  endtask : cmp_rx
  task automatic cmp_pin(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp(what, exp, got);
  endtask : cmp_pin
  task automatic cmp_cnt(input string what, input logic [31:0] exp, input logic [31:0] got);
    cmp(what, exp, got);
  endtask : cmp_cnt
  task automatic reg_write(input logic [ICD_AW-1:0] a, input logic [ICD_DW-1:0] d);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'H1;
    @(posedge sys_clk);
    reg_wr <= 1'H0;
  endtask : reg_write
  task automatic reg_read(input logic [ICD_AW-1:0] a, input logic [ICD_DW-1:0] exp);
    @(posedge sys_clk);
    reg_addr <= a;
    reg_rd <= 1'H1;
    rd_q.push_back(exp);
    @(posedge sys_clk);
    reg_rd <= 1'H0;
  endtask : reg_read
  task automatic chk();
    reg_read(ICD_OFS_STATUS, {23'H0, an, rn, tf, sq, sp, lk, rm, t, l});
    cmp_pin("lines", {30'H0, rm, lk}, {30'H0, remote, lockout});
  endtask : chk
  task automatic cmd(input logic [7:0] b);
    i_ctl.send(b, 1'H1, 1'H0);
    an = 1'H1;
  endtask : cmd
  task automatic dat(input logic [7:0] b, input logic e);
    if (l) rx_q.push_back({e, b[6:0]});
    i_ctl.send(b, 1'H0, e);
    an = 1'H0;
  endtask : dat
  ////////////////////////////////////////////////////////////////////////////
  // read data stand only in the cycle after the strobe
  always @(posedge sys_clk) begin
    rd_d <= reg_rd;
    cyc++;
    if (rd_d) cmp_rd(rd_q.size() ? rd_q.pop_front() : 32'HFFFFFFFF, reg_rdata);
    if (rx_valid) cmp_rx(rx_q.size() ? {1'H0, rx_q.pop_front()} : 9'H1FF,
      {1'H0, rx_last, rx_char});
    if (trigger) n_trig++;
    if (dev_clear) n_clr++;
    if (cyc == 20000) begin
      n_fail++;
      print_verdict();
    end
  end
  initial begin
    {rstn, reg_wr, reg_rd, tx_accept} = '0;
    reg_addr = '0;
    reg_wdata = '0;
    {l, t, rm, lk, sp, sq, tf, rn, an} = '0;
    repeat (8) @(posedge sys_clk);
    rstn <= 1'H1;
    chk();
    reg_read(ICD_OFS_CTRL, {27'H0, ICD_ADDR_RST});
    reg_read(8'H0C, 32'H0);
    i_ctl.lines(1'H0, 1'H1, 1'H0);
    rn = 1'H1;
    cmd({1'H0, ICD_UNL});
    cmd(8'HAA);
    {l, rm} = 2'H3;
    chk();
    cmd({1'H0, ICD_GET});
    cmd({1'H0, ICD_SDC});
    dat(8'HC6, 1'H0);
    dat(8'H30, 1'H0);
    dat(8'H58, 1'H1);
    cmd({1'H0, ICD_GTL});
    rm = 1'H0;
    cmd({1'H0, ICD_UNL});
    l = 1'H0;
    cmd({1'H0, ICD_GET});
    cmd({1'H0, ICD_SDC});
    dat(8'H41, 1'H0);
    chk();
    cmp_cnt("trig", 32'H1, 32'(n_trig));
    cmd({1'H0, ICD_DCL});
    cmp_cnt("clr", 32'H2, 32'(n_clr));
    cmd({1'H0, ICD_LLO});
    cmd({1'H0, ICD_SPE});
    {lk, sp} = 2'H3;
    chk();
    cmd({1'H0, ICD_SPD});
    sp = 1'H0;
    pa = 5'(($random(seed) & 32'H7FFFFFFF) % 31);
    reg_write(ICD_OFS_CTRL, 32'H100 | {27'H0, pa});
    sq = 1'H1;
    repeat (2) @(posedge sys_clk);
    cmp_pin("srq", 32'H2, {30'H0, srq_oe, srq_n_out});
    cmd({1'H0, ICD_GRP_TAG, pa});
    t = 1'H1;
    cmd({1'H0, ICD_GRP_SCG, pa});
    chk();
    cmd({1'H0, ICD_SPE});
    cmd({1'H0, ICD_GRP_TAG, pa});
    cmd({1'H0, ICD_SPD});
    sq = 1'H0;
    reg_write(ICD_OFS_CTRL, 32'H1F);
    reg_read(ICD_OFS_CTRL, {27'H0, pa});
    chk();
    i_ctl.lines(1'H0, 1'H1, 1'H0);
    an = 1'H0;
    reg_write(ICD_OFS_TXDATA, 32'H141);
    repeat (3) @(posedge sys_clk);
    cmp_pin("tx", 32'H1BE02, {dio_oe, dio_n_out, 6'H0, eoi_oe, eoi_n_out});
    tf = 1'H1;
    chk();
    tx_accept <= 1'H1;
    @(posedge sys_clk);
    tx_accept <= 1'H0;
    tf = 1'H0;
    chk();
    cmd({1'H0, ICD_UNT});
    t = 1'H0;
    chk();
    cmd({1'H0, ICD_GRP_LAG, pa});
    cmd({1'H0, ICD_GRP_TAG, pa});
    {l, t, rm} = 3'H7;
    chk();
    i_ctl.lines(1'H1, 1'H1, 1'H1);
    {l, t} = 2'H0;
    chk();
    i_ctl.lines(1'H0, 1'H0, 1'H0);
    {an, rn, rm, lk} = 4'H0;
    chk();
    repeat (4) @(posedge sys_clk);
    print_verdict();
  end
endmodule : icd_top_tb
`default_nettype wire
